// File: rtl/vfs_top.sv
// Alarm supervision of air conditioning and gas cooler bypass valves.
// Assumes field inputs are asynchronous, commands and analogue codes are on clk.
// Notes on behaviour
// - Pump fault alarms and closes refrigerant valve.
// - Changeover valve mismatch for 300 s faults.
// - Refrigerant valve mismatch for 300 s faults.
// - Emergency stop de-energised stops air conditioning.
// - Parameter violation blocks and flags bypass.
// - Switched bypass valve mismatch 300 s faults.
// - Analogue bypass deviation 1.8 V faults.
`timescale 1ns/1ps
module vfs_top #(
  parameter int RUN_TICKS = vfs_pkg::RUN_TICKS,
  parameter int CODE_W = vfs_pkg::CODE_W
) (
  // Clock, reset, timebase
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tick_1s,
  // Field inputs, asynchronous
  input wire logic pump_fault_pin,
  input wire logic estop_ac_ok_pin,
  input wire logic chg_fb_lowtemp_pin,
  input wire logic chg_fb_ac_pin,
  input wire logic ref_fb_open_pin,
  input wire logic ref_fb_closed_pin,
  input wire logic bp_fb_open_pin,
  input wire logic bp_fb_closed_pin,
  // Commands from control logic
  input wire logic ac_request,
  input wire logic chg_cmd_ac,
  input wire logic ref_open_request,
  input wire logic bp_param_violation,
  input wire logic bp_analog_mode,
  input wire logic bp_open_request,
  input wire logic [CODE_W-1:0] bp_ctrl_code,
  input wire logic [CODE_W-1:0] bp_readback_code,
  input wire logic alarm_clear,
  // Actuation
  output logic ac_enable,
  output logic ref_valve_open,
  output logic bp_valve_open,
  output logic [CODE_W-1:0] bp_ctrl_out,
  // Alarms
  output logic alarm_pump,
  output logic alarm_estop,
  output logic alarm_chg_valve,
  output logic alarm_ref_valve,
  output logic alarm_bp_disabled,
  output logic alarm_bp_valve
);
  localparam int NP = vfs_pkg::PIN_COUNT;

  // Refused at elaboration, the deviation products are sized for 16 bits
  if (CODE_W < 2 || CODE_W > 16) begin : g_bad_code
    $error("CODE_W must lie in 2..16");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NP-1:0] pins;
  logic [NP-1:0] sync1_r;
  logic [NP-1:0] sync2_r;
  assign pins = {bp_fb_closed_pin, bp_fb_open_pin, ref_fb_closed_pin, ref_fb_open_pin,
                 chg_fb_ac_pin, chg_fb_lowtemp_pin, estop_ac_ok_pin, pump_fault_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sync1_r[gi] <= vfs_pkg::RST_PINS[gi];
          sync2_r[gi] <= vfs_pkg::RST_PINS[gi];
        end else if (ce) begin
          sync1_r[gi] <= pins[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic pump_flt;
  logic estop_ok;
  assign pump_flt = sync2_r[vfs_pkg::PIN_PUMP_FAULT];
  assign estop_ok = sync2_r[vfs_pkg::PIN_ESTOP_OK];

  // ****************************************
  // Analogue deviation
  // ****************************************
  // Compared in millivolt products to avoid rounding the limit to a code
  function automatic logic dev_too_big(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
    logic [CODE_W-1:0] d;
    logic [31:0] lhs;
    logic [31:0] rhs;
    d = (a > b) ? (a - b) : (b - a);
    lhs = 32'(d) * 32'(vfs_pkg::FULL_SCALE_MV);
    rhs = 32'(vfs_pkg::DEV_LIMIT_MV) * 32'(vfs_pkg::FULL_SCALE_CODE);
    return lhs >= rhs;
  endfunction : dev_too_big

  logic dev_big;
  assign dev_big = dev_too_big(bp_ctrl_code, bp_readback_code);

  // ****************************************
  // Valve timers
  // ****************************************
  logic chg_timeout;
  logic ref_timeout;
  logic bp_timeout;
  logic bp_dig_active;
  logic ref_open_r, ref_open_nxt;
  logic bp_open_r, bp_open_nxt;

  vfs_valve_timer #(.RUN_TICKS(RUN_TICKS)) u_chg_timer (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .tick(tick_1s),
    .active(1'b1),
    .cmd_open(chg_cmd_ac),
    .fb_open(sync2_r[vfs_pkg::PIN_CHG_AC]),
    .fb_closed(sync2_r[vfs_pkg::PIN_CHG_LOWTEMP]),
    .timeout(chg_timeout)
  );

  // Compared against the drive actually sent, not the request
  vfs_valve_timer #(.RUN_TICKS(RUN_TICKS)) u_ref_timer (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .tick(tick_1s),
    .active(1'b1),
    .cmd_open(ref_open_r),
    .fb_open(sync2_r[vfs_pkg::PIN_REF_OPEN]),
    .fb_closed(sync2_r[vfs_pkg::PIN_REF_CLOSED]),
    .timeout(ref_timeout)
  );

  assign bp_dig_active = !bp_analog_mode && !bp_param_violation;

  vfs_valve_timer #(.RUN_TICKS(RUN_TICKS)) u_bp_timer (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .tick(tick_1s),
    .active(bp_dig_active),
    .cmd_open(bp_open_r),
    .fb_open(sync2_r[vfs_pkg::PIN_BP_OPEN]),
    .fb_closed(sync2_r[vfs_pkg::PIN_BP_CLOSED]),
    .timeout(bp_timeout)
  );

  // ****************************************
  // Actuation and alarms
  // ****************************************
  logic ac_en_r, ac_en_nxt;
  logic [CODE_W-1:0] bp_ctrl_r, bp_ctrl_nxt;
  logic al_pump_r, al_pump_nxt;
  logic al_estop_r, al_estop_nxt;
  logic al_chg_r, al_chg_nxt;
  logic al_ref_r, al_ref_nxt;
  logic al_bpdis_r, al_bpdis_nxt;
  logic al_bpv_r, al_bpv_nxt;
  logic bp_analog_err;

  assign bp_analog_err = bp_analog_mode && !bp_param_violation && dev_big;

  always_comb begin
    al_pump_nxt = pump_flt;
    al_estop_nxt = !estop_ok;
    ac_en_nxt = ac_request && estop_ok;
    // Open feeds the exchanger; a pump fault or stop forces the bypass path
    ref_open_nxt = ref_open_request && ac_en_nxt && !pump_flt;
    al_bpdis_nxt = bp_param_violation;
    bp_open_nxt = bp_open_request && !bp_param_violation && !bp_analog_mode;
    bp_ctrl_nxt = (bp_param_violation || !bp_analog_mode) ? '0 : bp_ctrl_code;
    // Valve faults latch; a new cause wins over a clear in the same cycle
    al_chg_nxt = chg_timeout || (al_chg_r && !alarm_clear);
    al_ref_nxt = ref_timeout || (al_ref_r && !alarm_clear);
    al_bpv_nxt = bp_timeout || bp_analog_err || (al_bpv_r && !alarm_clear);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ac_en_r <= vfs_pkg::RST_DRIVE;
      ref_open_r <= vfs_pkg::RST_DRIVE;
      bp_open_r <= vfs_pkg::RST_DRIVE;
      bp_ctrl_r <= '0;
      al_pump_r <= vfs_pkg::RST_ALARM;
      al_estop_r <= vfs_pkg::RST_ALARM;
      al_chg_r <= vfs_pkg::RST_ALARM;
      al_ref_r <= vfs_pkg::RST_ALARM;
      al_bpdis_r <= vfs_pkg::RST_ALARM;
      al_bpv_r <= vfs_pkg::RST_ALARM;
    end else if (ce) begin
      ac_en_r <= ac_en_nxt;
      ref_open_r <= ref_open_nxt;
      bp_open_r <= bp_open_nxt;
      bp_ctrl_r <= bp_ctrl_nxt;
      al_pump_r <= al_pump_nxt;
      al_estop_r <= al_estop_nxt;
      al_chg_r <= al_chg_nxt;
      al_ref_r <= al_ref_nxt;
      al_bpdis_r <= al_bpdis_nxt;
      al_bpv_r <= al_bpv_nxt;
    end
  end

  assign ac_enable = ac_en_r;
  assign ref_valve_open = ref_open_r;
  assign bp_valve_open = bp_open_r;
  assign bp_ctrl_out = bp_ctrl_r;
  assign alarm_pump = al_pump_r;
  assign alarm_estop = al_estop_r;
  assign alarm_chg_valve = al_chg_r;
  assign alarm_ref_valve = al_ref_r;
  assign alarm_bp_disabled = al_bpdis_r;
  assign alarm_bp_valve = al_bpv_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pump_closes_valve: assert property ((ce && pump_flt) |=> (al_pump_r && !ref_open_r))
    else $error("pump fault did not close refrigerant valve");
  a_pin_to_close: assert property ((ce && sync1_r[vfs_pkg::PIN_PUMP_FAULT]) ##1 ce |=> !ref_open_r)
    else $error("refrigerant valve open two cycles after pump fault");
  a_chg_fault_cause: assert property ($rose(al_chg_r) |-> $past(chg_timeout))
    else $error("changeover fault without timeout");
  a_ref_fault_hold: assert property ((al_ref_r && !alarm_clear) |=> al_ref_r)
    else $error("refrigerant valve fault dropped without clear");
  a_ref_open_cause: assert property ($rose(ref_open_r) |-> ($past(ref_open_request) && $past(estop_ok)))
    else $error("refrigerant valve opened without request");
  a_estop_stops_ac: assert property ((ce && !estop_ok) |=> (!ac_en_r && al_estop_r && !ref_open_r))
    else $error("emergency stop did not shut down air conditioning");
  a_bp_blocked: assert property ((ce && bp_param_violation) |=> (al_bpdis_r && !bp_open_r && bp_ctrl_r == '0))
    else $error("bypass not blocked on parameter violation");
  a_bp_dig_fault: assert property ((ce && bp_timeout) |=> al_bpv_r)
    else $error("bypass timeout not flagged");
  a_bp_analog_fault: assert property ((ce && bp_analog_err) |=> al_bpv_r)
    else $error("analogue bypass deviation not flagged");
  a_bp_fault_cause: assert property ($rose(al_bpv_r) |-> ($past(bp_timeout) || $past(bp_analog_err)))
    else $error("bypass fault without cause");

  c_pump_fault: cover property ((ce && pump_flt) ##1 al_pump_r);
  c_ref_timeout: cover property ($rose(al_ref_r));
  c_bp_analog: cover property ((ce && bp_analog_err) ##1 al_bpv_r);
  c_estop: cover property ($rose(al_estop_r));
endmodule : vfs_top

// File: inc/vfs_pkg.sv
// Shared constants of the valve fault supervisor.
// Assumes a one-second tick pulse from the system timebase.
package vfs_pkg;
  // ****************************************
  // Valve running time
  // ****************************************
  localparam int VALVE_RUN_S = 300;
  localparam int TICK_PERIOD_S = 1;
  localparam int RUN_TICKS = VALVE_RUN_S / TICK_PERIOD_S;
  // ****************************************
  // Analogue read-back of the bypass valve
  // ****************************************
  localparam int CODE_W = 12;
  localparam int FULL_SCALE_MV = 10000;
  localparam int FULL_SCALE_CODE = 4095;
  localparam int DEV_LIMIT_MV = 1800;
  // ****************************************
  // Synchronised pin positions
  // ****************************************
  localparam int PIN_PUMP_FAULT = 0;
  localparam int PIN_ESTOP_OK = 1;
  localparam int PIN_CHG_LOWTEMP = 2;
  localparam int PIN_CHG_AC = 3;
  localparam int PIN_REF_OPEN = 4;
  localparam int PIN_REF_CLOSED = 5;
  localparam int PIN_BP_OPEN = 6;
  localparam int PIN_BP_CLOSED = 7;
  localparam int PIN_COUNT = 8;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_ALARM = 1'b0;
  localparam logic RST_DRIVE = 1'b0;
  localparam logic [PIN_COUNT-1:0] RST_PINS = 8'h02;
endpackage : vfs_pkg

// File: rtl/vfs_valve_timer.sv
// Running-time supervision of one valve with two end-position feedbacks.
// Assumes synchronised feedbacks and a tick pulse on clk.
`timescale 1ns/1ps
module vfs_valve_timer #(
  parameter int RUN_TICKS = vfs_pkg::RUN_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tick,
  // Valve
  input wire logic active,
  input wire logic cmd_open,
  input wire logic fb_open,
  input wire logic fb_closed,
  output logic timeout
);
  localparam int CW = $clog2(RUN_TICKS + 1);
  localparam logic [CW-1:0] LIMIT = CW'(RUN_TICKS);

  // Refused at elaboration, a zero running time would fault at once
  if (RUN_TICKS < 1) begin : g_bad_run
    $error("RUN_TICKS must be at least 1");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic timeout_r;
  logic timeout_nxt;
  logic agree;

  // A valve is in position only with exactly the commanded switch made
  assign agree = cmd_open ? (fb_open && !fb_closed) : (fb_closed && !fb_open);
  assign timeout = timeout_r;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!active || agree) begin
      cnt_nxt = '0;
    end else if (tick && cnt_r != LIMIT) begin
      cnt_nxt = cnt_r + CW'(1);
    end
    timeout_nxt = active && !agree && (cnt_nxt == LIMIT);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      timeout_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_timer_restart: assert property (@(posedge clk) disable iff (!rstn)
    (ce && (agree || !active)) |=> (cnt_r == '0 && !timeout_r))
    else $error("running timer not restarted on agreement");
  a_timer_full: assert property (@(posedge clk) disable iff (!rstn)
    $rose(timeout_r) |-> (cnt_r == LIMIT && !$past(agree)))
    else $error("timeout raised before full running time");
endmodule : vfs_valve_timer

// File: bench/vfs_field_model.sv
// Field model of the three supervised valves and their end switches.
// Assumes drives on clk; a stuck valve stays where it stands.
`timescale 1ns/1ps
module vfs_field_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Drives and injected faults
  input wire logic chg_ac,
  input wire logic ref_open,
  input wire logic bp_open,
  input wire logic [2:0] stuck,
  // End switches
  output logic chg_lt_made,
  output logic chg_ac_made,
  output logic ref_open_made,
  output logic ref_closed_made,
  output logic bp_open_made,
  output logic bp_closed_made
);
  logic [2:0] pos_r;
  // One cycle of travel; real valves take far longer but the timer only sees agreement
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_r <= 3'h0;
    end else begin
      pos_r <= (pos_r & stuck) | ({bp_open, ref_open, chg_ac} & ~stuck);
    end
  end
  assign chg_ac_made = pos_r[0];
  assign chg_lt_made = ~pos_r[0];
  assign ref_open_made = pos_r[1];
  assign ref_closed_made = ~pos_r[1];
  assign bp_open_made = pos_r[2];
  assign bp_closed_made = ~pos_r[2];
endmodule : vfs_field_model

// File: bench/vfs_top_bench.sv
// Self-checking bench of the valve fault supervisor.
// Assumes a shortened running time of three ticks, one tick per 8 clocks.
`timescale 1ns/1ps
module vfs_top_bench;
  logic clk, rstn, ce, tick_1s, pump, estop, ac_req, chg_ac, ref_req, viol, amode, bp_req, clr;
  logic [11:0] ctrl, rdbk, bp_out;
  logic [2:0] stuck, tick_cnt;
  logic chg_lt, chg_a, ref_o, ref_c, bp_o, bp_c, e, l, c;
  logic ac_en, ref_drv, bp_drv, a_pump, a_estop, a_chg, a_ref, a_dis, a_bp;
  int bad_count, compares;
  vfs_top #(.RUN_TICKS(3)) dut_u (.clk(clk), .rstn(rstn), .ce(ce), .tick_1s(tick_1s),
    .pump_fault_pin(pump), .estop_ac_ok_pin(estop), .chg_fb_lowtemp_pin(chg_lt),
    .chg_fb_ac_pin(chg_a), .ref_fb_open_pin(ref_o), .ref_fb_closed_pin(ref_c),
    .bp_fb_open_pin(bp_o), .bp_fb_closed_pin(bp_c), .ac_request(ac_req), .chg_cmd_ac(chg_ac),
    .ref_open_request(ref_req), .bp_param_violation(viol), .bp_analog_mode(amode),
    .bp_open_request(bp_req), .bp_ctrl_code(ctrl), .bp_readback_code(rdbk), .alarm_clear(clr),
    .ac_enable(ac_en), .ref_valve_open(ref_drv), .bp_valve_open(bp_drv), .bp_ctrl_out(bp_out),
    .alarm_pump(a_pump), .alarm_estop(a_estop), .alarm_chg_valve(a_chg),
    .alarm_ref_valve(a_ref), .alarm_bp_disabled(a_dis), .alarm_bp_valve(a_bp));
  vfs_field_model field_u (.clk(clk), .rstn(rstn), .chg_ac(chg_ac), .ref_open(ref_drv),
    .bp_open(bp_drv), .stuck(stuck), .chg_lt_made(chg_lt), .chg_ac_made(chg_a),
    .ref_open_made(ref_o), .ref_closed_made(ref_c), .bp_open_made(bp_o), .bp_closed_made(bp_c));
  // ****************************************
  // Clock, timebase and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 3'h0;
      tick_1s <= 1'b0;
    end else begin
      tick_cnt <= tick_cnt + 3'h1;
      tick_1s <= (tick_cnt == 3'h7);
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  function logic alarm_of(input int v);
    return (v == 0) ? a_chg : (v == 1) ? a_ref : a_bp;
  endfunction : alarm_of
  task flip(input int v);
    @(posedge clk);
    case (v)
      0: chg_ac <= ~chg_ac;
      1: ref_req <= ~ref_req;
      default: bp_req <= ~bp_req;
    endcase
  endtask : flip
  // Short mismatch, agreement, then one mismatch sampled short and again long; 12 clocks hold at most two ticks
  task mismatch_run(input int v, output logic early, output logic late, output logic cleared);
    @(posedge clk);
    stuck[v] <= 1'b1;
    flip(v); cyc(12); flip(v); cyc(4); flip(v); cyc(12);
    #1 early = alarm_of(v);
    cyc(30);
    #1 late = alarm_of(v);
    @(posedge clk);
    stuck[v] <= 1'b0;
    cyc(6);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cyc(2);
    #1 cleared = alarm_of(v);
  endtask : mismatch_run
  // ****************************************
  // Scenarios
  // ****************************************
  task s_pump;
    @(posedge clk);
    ref_req <= 1'b1;
    cyc(4);
    #1 chk(ref_drv, 1'b1);
    chk(ref_o, 1'b1);
    chk(a_pump, 1'b0);
    @(posedge clk);
    pump <= 1'b1;
    cyc(3);
    #1 chk(a_pump, 1'b1);
    chk(ref_drv, 1'b0);
    @(posedge clk);
    pump <= 1'b0;
    cyc(4);
    #1 chk(ref_drv, 1'b1);
  endtask : s_pump
  task s_estop;
    @(posedge clk);
    estop <= 1'b0;
    cyc(3);
    #1 chk(a_estop, 1'b1);
    chk(ac_en, 1'b0);
    @(posedge clk);
    estop <= 1'b1;
    cyc(4);
    #1 chk(ac_en, 1'b1);
    chk(a_estop, 1'b0);
  endtask : s_estop
  task s_chg;
    mismatch_run(0, e, l, c);
    chk(e, 1'b0);
    chk(l, 1'b1);
    chk(c, 1'b0);
  endtask : s_chg
  task s_ref;
    mismatch_run(1, e, l, c);
    chk(e, 1'b0);
    chk(l, 1'b1);
    chk(c, 1'b0);
  endtask : s_ref
  task s_bp;
    mismatch_run(2, e, l, c);
    chk(e, 1'b0);
    chk(l, 1'b1);
    chk(c, 1'b0);
  endtask : s_bp
  task s_block;
    @(posedge clk);
    bp_req <= 1'b1;
    viol <= 1'b1;
    cyc(2);
    #1 chk(a_dis, 1'b1);
    chk(bp_drv, 1'b0);
    @(posedge clk);
    amode <= 1'b1;
    ctrl <= 12'h400;
    rdbk <= 12'h000;
    cyc(2);
    #1 chk(bp_out, 12'h000);
    chk(a_bp, 1'b0);
    @(posedge clk);
    viol <= 1'b0;
    rdbk <= 12'h400;
    cyc(2);
    #1 chk(a_dis, 1'b0);
    chk(bp_out, 12'h400);
  endtask : s_block
  // 1.8 V of 10 V on 4095 codes is 737.1 codes: 737 passes, 738 faults either way
  task s_analog;
    @(posedge clk);
    rdbk <= 12'h6E1;
    cyc(2);
    #1 chk(a_bp, 1'b0);
    @(posedge clk);
    rdbk <= 12'h6E2;
    cyc(2);
    #1 chk(a_bp, 1'b1);
    @(posedge clk);
    rdbk <= 12'h400;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cyc(2);
    #1 chk(a_bp, 1'b0);
    @(posedge clk);
    rdbk <= 12'h11E;
    cyc(2);
    #1 chk(a_bp, 1'b1);
  endtask : s_analog
  // Clock enable low freezes the synchronisers, so a pump fault waits for it
  task s_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pump <= 1'b1;
    cyc(6);
    #1 chk(a_pump, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    cyc(3);
    #1 chk(a_pump, 1'b1);
    chk(ref_drv, 1'b0);
    @(posedge clk);
    pump <= 1'b0;
    cyc(4);
    #1 chk(a_pump, 1'b0);
  endtask : s_freeze
  // ****************************************
  // Main sequence and run limit
  // ****************************************
  initial begin
    {rstn, pump, ac_req, chg_ac, ref_req, viol, amode, bp_req, clr} = 9'h000;
    ce = 1'b1;
    estop = 1'b1;
    ctrl = 12'h000;
    rdbk = 12'h000;
    stuck = 3'h0;
    bad_count = 0;
    compares = 0;
    cyc(20);
    rstn <= 1'b1;
    @(posedge clk);
    ac_req <= 1'b1;
    s_pump();
    s_estop();
    s_chg();
    s_ref();
    s_bp();
    s_block();
    s_analog();
    s_freeze();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    $display("BAD %0t run limit reached", $time);
    bad_count++;
    complete_run();
  end
endmodule : vfs_top_bench
